// ### core/psw_pkg.sv
// Package: constants and types for the processor supervisor watchdog
package psw_pkg;

	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned CLK_PERIOD_NS   = 40;

	// Times in microseconds as printed
	localparam int unsigned HOLD_US         = 250000;
	localparam int unsigned BUTTON_DELAY_US = 10000;
	localparam int unsigned WD_SHORT_US     = 150000;
	localparam int unsigned WD_MID_US       = 600000;
	localparam int unsigned WD_LONG_US      = 1200000;

	// Cycle counts: least times round up
	localparam longint unsigned HOLD_CYC =
		(64'(HOLD_US) * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint unsigned BUTTON_DELAY_CYC =
		(64'(BUTTON_DELAY_US) * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint unsigned WD_SHORT_CYC =
		(64'(WD_SHORT_US) * 1000) / CLK_PERIOD_NS;
	localparam longint unsigned WD_MID_CYC =
		(64'(WD_MID_US) * 1000) / CLK_PERIOD_NS;
	localparam longint unsigned WD_LONG_CYC =
		(64'(WD_LONG_US) * 1000) / CLK_PERIOD_NS;

	localparam int unsigned CNT_W = 26;

	// Three-level select, decoded from two pins
	localparam logic [1:0] SEL_GROUND = 2'h0;
	localparam logic [1:0] SEL_FLOAT  = 2'h1;
	localparam logic [1:0] SEL_SUPPLY = 2'h2;

	typedef enum logic [1:0] {
		PSW_HOLD,
		PSW_RUN,
		PSW_FORCED
	} psw_state_type;

endpackage

// ### core/psw_debounce.sv
// Manual reset input synchroniser and debouncer
`timescale 1ns/1ns
module psw_debounce #(
	parameter int unsigned DELAY_CYC = 250000
) (
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic pin_n,
	output logic      pressed
);

	typedef struct packed {
		logic        s1;
		logic        s2;
		logic [25:0] cnt;
		logic        pressed;
	} psw_deb_type;

	psw_deb_type st_q;
	psw_deb_type st_d;

	localparam logic [25:0] LIMIT = 26'(DELAY_CYC - 1);

	always_comb begin
		st_d = st_q;
		st_d.s1 = pin_n;
		st_d.s2 = st_q.s1;
		// Low must persist; any high restarts the count
		if (st_q.s2) begin
			st_d.cnt = '0;
			st_d.pressed = 1'b0;
		end else if (st_q.cnt >= LIMIT) begin
			st_d.pressed = 1'b1;
		end else begin
			st_d.cnt = st_q.cnt + 26'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st_q <= '{s1: 1'b1, s2: 1'b1, cnt: '0, pressed: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign pressed = st_q.pressed;

endmodule // psw_debounce

// ### core/psw_top.sv
// Processor supervisor: reset generator with watchdog
// Function
// - Reset outputs go active once manual reset has been low for the delay.
// - Reset stays active at least 250 ms after manual reset returns high.
// - Manual reset lows under 1 ms are ignored, 20 ms or more always act.
// - No kick within the selected period forces both reset outputs active.
// - Timeout select picks 150, 600 or 1200 ms for ground, float, supply.
// - The watchdog times only once reset is released, never during reset.
// - A falling kick edge before expiry restarts a full period.
// - Watchdog expiry asserts reset for at least 250 ms.
// - Only falling kick edges count; rising edges and levels do not.
// - Periods fall within 62.5-250, 250-1000 and 500-2000 ms.
// - An active-high push-pull and active-low open-drain reset move together; the open-drain is driven low only while reset is inactive.
// - Undervoltage forces reset and holds it 250 ms after it clears.
`timescale 1ns/1ns
module psw_top #(
	parameter longint unsigned HOLD_CYC     = psw_pkg::HOLD_CYC,
	parameter longint unsigned BUTTON_CYC   = psw_pkg::BUTTON_DELAY_CYC,
	parameter longint unsigned WD_SHORT_CYC = psw_pkg::WD_SHORT_CYC,
	parameter longint unsigned WD_MID_CYC   = psw_pkg::WD_MID_CYC,
	parameter longint unsigned WD_LONG_CYC  = psw_pkg::WD_LONG_CYC
) (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       manual_reset_n,
	input  wire logic       watchdog_kick_n,
	input  wire logic [1:0] timeout_select,
	input  wire logic       undervoltage,
	output logic            reset_out,
	output logic            reset_out_n_o,
	output logic            reset_out_n_oe
);

	localparam int unsigned W = psw_pkg::CNT_W;

	typedef struct packed {
		logic [1:0]              uv_sync;
		logic [1:0]              kick_sync;
		logic                    kick_prev;
		logic [1:0]              sel_sync0;
		logic [1:0]              sel_sync1;
		psw_pkg::psw_state_type  state;
		logic [W-1:0]            cnt;
		logic                    rst_active;
	} psw_top_type;

	psw_top_type st_q;
	psw_top_type st_d;
	logic        button_pressed;

	// Period for the selected timeout level
	function automatic logic [W-1:0] period_of(input logic [1:0] sel);
		case (sel)
			psw_pkg::SEL_GROUND: period_of = W'(WD_SHORT_CYC);
			psw_pkg::SEL_FLOAT:  period_of = W'(WD_MID_CYC);
			psw_pkg::SEL_SUPPLY: period_of = W'(WD_LONG_CYC);
			default:             period_of = W'(WD_MID_CYC);
		endcase
	endfunction

	psw_debounce #(
		.DELAY_CYC (int'(BUTTON_CYC))
	) u_debounce (
		.clock   (clock),
		.rst_b   (rst_b),
		.pin_n   (manual_reset_n),
		.pressed (button_pressed)
	);

	////////////////////////////////////////////////////////////////////////
	logic kick_fall;
	logic force_src;

	always_comb begin
		st_d = st_q;
		st_d.uv_sync   = {st_q.uv_sync[0], undervoltage};
		st_d.kick_sync = {st_q.kick_sync[0], watchdog_kick_n};
		st_d.kick_prev = st_q.kick_sync[1];
		st_d.sel_sync0 = timeout_select;
		st_d.sel_sync1 = st_q.sel_sync0;
		// One pulse per high-to-low transition only
		kick_fall = st_q.kick_prev & ~st_q.kick_sync[1];
		force_src = button_pressed | st_q.uv_sync[1];

		case (st_q.state)
			psw_pkg::PSW_FORCED: begin
				st_d.rst_active = 1'b1;
				st_d.cnt = '0;
				if (!force_src) begin
					st_d.state = psw_pkg::PSW_HOLD;
				end
			end
			psw_pkg::PSW_HOLD: begin
				st_d.rst_active = 1'b1;
				if (force_src) begin
					st_d.state = psw_pkg::PSW_FORCED;
					st_d.cnt = '0;
				end else if (st_q.cnt >= W'(HOLD_CYC - 1)) begin
					// Watchdog starts fresh on release
					st_d.state = psw_pkg::PSW_RUN;
					st_d.rst_active = 1'b0;
					st_d.cnt = '0;
				end else begin
					st_d.cnt = st_q.cnt + W'(1);
				end
			end
			psw_pkg::PSW_RUN: begin
				st_d.rst_active = 1'b0;
				if (force_src) begin
					st_d.state = psw_pkg::PSW_FORCED;
					st_d.rst_active = 1'b1;
					st_d.cnt = '0;
				end else if (kick_fall) begin
					st_d.cnt = '0;
				end else if (st_q.cnt >= period_of(st_q.sel_sync1) - W'(1)) begin
					// Expiry: hold reset the full interval
					st_d.state = psw_pkg::PSW_HOLD;
					st_d.rst_active = 1'b1;
					st_d.cnt = '0;
				end else begin
					st_d.cnt = st_q.cnt + W'(1);
				end
			end
			default: begin
				st_d.state = psw_pkg::PSW_HOLD;
				st_d.rst_active = 1'b1;
				st_d.cnt = '0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Power-up reset enters hold with outputs active
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st_q <= '{uv_sync: 2'h0, kick_sync: 2'h3, kick_prev: 1'b1,
				sel_sync0: 2'h0, sel_sync1: 2'h0,
				state: psw_pkg::PSW_HOLD, cnt: '0, rst_active: 1'b1};
			reset_out <= 1'b1;
			reset_out_n_o <= 1'b0;
			reset_out_n_oe <= 1'b0;
		end else begin
			st_q <= st_d;
			// Both outputs share one flop's next value
			reset_out <= st_d.rst_active;
			reset_out_n_o <= 1'b0;
			reset_out_n_oe <= ~st_d.rst_active;
		end
	end

endmodule // psw_top

// ### tb/psw_assertions.sv
// Checker: reset output timing of the supervisor
`timescale 1ns/1ns
module psw_assertions #(
	parameter longint unsigned HOLD_CYC     = 50,
	parameter longint unsigned BUTTON_CYC   = 10,
	parameter longint unsigned WD_SHORT_CYC = 100,
	parameter longint unsigned WD_MID_CYC   = 200,
	parameter longint unsigned WD_LONG_CYC  = 300
) (
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic       manual_reset_n,
	input wire logic       watchdog_kick_n,
	input wire logic [1:0] timeout_select,
	input wire logic       undervoltage,
	input wire logic       reset_out,
	input wire logic       reset_out_n_o,
	input wire logic       reset_out_n_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	logic [31:0] hi_q, lo_q, bt_q;
	longint unsigned wd;
	assign wd = timeout_select == 2'h0 ? WD_SHORT_CYC :
		timeout_select == 2'h2 ? WD_LONG_CYC : WD_MID_CYC;
	// Run lengths: reset high, quiet kick line, button held
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			hi_q <= 32'h0;
			lo_q <= 32'h0;
			bt_q <= 32'h0;
		end else begin
			hi_q <= reset_out ? hi_q + 32'h1 : 32'h0;
			lo_q <= reset_out || $fell(watchdog_kick_n) ? 32'h0 : lo_q + 32'h1;
			bt_q <= manual_reset_n ? 32'h0 : bt_q + 32'h1;
		end
	end
	property p_pair; reset_out == !reset_out_n_oe; endproperty
	a_pair: assert property (p_pair) else $error("outputs split");
	property p_od; reset_out_n_o == 1'b0; endproperty
	a_od: assert property (p_od) else $error("drain data high");
	property p_por; disable iff (1'b0) !rst_b |=> reset_out; endproperty
	a_por: assert property (p_por) else $error("no power-up reset");
	property p_hold; $fell(reset_out) |-> hi_q >= HOLD_CYC; endproperty
	a_hold: assert property (p_hold) else $error("hold short");
	property p_wd; lo_q <= wd + 8; endproperty
	a_wd: assert property (p_wd) else $error("no expiry");
	property p_btn; bt_q > BUTTON_CYC + 5 |-> reset_out; endproperty
	a_btn: assert property (p_btn) else $error("press ignored");
	property p_uv; undervoltage [*3] |=> ##[0:2] reset_out; endproperty
	a_uv: assert property (p_uv) else $error("supply ignored");
	property p_uvh;
		undervoltage [*2] ##1 !undervoltage |=> reset_out [*8];
	endproperty
	a_uvh: assert property (p_uvh) else $error("supply hold");
	c_rel: cover property ($fell(reset_out));
	c_wd: cover property ($rose(reset_out) && manual_reset_n && !undervoltage);
	c_btn: cover property (bt_q == 32'(BUTTON_CYC));
endmodule // psw_assertions
bind psw_top psw_assertions #(.HOLD_CYC(HOLD_CYC), .BUTTON_CYC(BUTTON_CYC),
	.WD_SHORT_CYC(WD_SHORT_CYC), .WD_MID_CYC(WD_MID_CYC),
	.WD_LONG_CYC(WD_LONG_CYC)) u_chk (.clock(clock), .rst_b(rst_b),
	.manual_reset_n(manual_reset_n), .watchdog_kick_n(watchdog_kick_n),
	.timeout_select(timeout_select), .undervoltage(undervoltage),
	.reset_out(reset_out), .reset_out_n_o(reset_out_n_o),
	.reset_out_n_oe(reset_out_n_oe));

// ### tb/psw_host.sv
// Host model: toggles the kick line while enabled
`timescale 1ns/1ns
module psw_host #(
	parameter int GAP = 30
) (
	input  wire logic clock,
	input  wire logic kick_en,
	output logic      watchdog_kick_n
);
	int cnt = 0;
	initial watchdog_kick_n = 1'b1;
	// Falls spaced well below the period; level static when stopped
	always @(negedge clock) begin
		cnt <= kick_en && cnt < GAP ? cnt + 1 : 0;
		if (kick_en && cnt >= GAP)
			watchdog_kick_n <= !watchdog_kick_n;
	end
endmodule // psw_host

// ### tb/psw_tb_top.sv
// Testbench: power-up, watchdog, button and supply scenarios
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
	error_cnt++; $display("Error %s exp %0d got %0d", nm, ex, got); end end
module psw_tb_top;
	localparam int HOLD = 50;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic manual_reset_n = 1'b1; // Logic-driven, idling high
	logic [1:0] timeout_select = 2'h0;
	logic undervoltage = 1'b0;
	logic kick_en = 1'b0;
	logic watchdog_kick_n, reset_out, seen;
	logic rst_od, rst_oe;
	int error_cnt = 0;
	int cmp_count = 0;
	int per[4] = '{100, 200, 300, 200};
	always #20 clock = ~clock;
	psw_host u_host (.clock(clock), .kick_en(kick_en),
		.watchdog_kick_n(watchdog_kick_n));
	psw_top #(.HOLD_CYC(HOLD), .BUTTON_CYC(10), .WD_SHORT_CYC(100),
		.WD_MID_CYC(200), .WD_LONG_CYC(300)) u_dut (.clock(clock),
		.rst_b(rst_b), .manual_reset_n(manual_reset_n),
		.watchdog_kick_n(watchdog_kick_n), .timeout_select(timeout_select),
		.undervoltage(undervoltage), .reset_out(reset_out),
		.reset_out_n_o(rst_od), .reset_out_n_oe(rst_oe));
	////////////////////////////////////////
	task automatic close_out();
		if (error_cnt == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wait_rst(input logic v, input int lim, output int n);
		n = 0;
		while (reset_out !== v && n < lim) begin
			@(negedge clock);
			n++;
		end
		if (reset_out !== v) begin
			`CHK("reset_out", v, reset_out)
			close_out();
		end
	endtask
	task automatic quiet(input int cyc);
		seen = 1'b0;
		repeat (cyc) begin
			@(negedge clock);
			seen |= reset_out;
		end
	endtask
	task automatic t_wd();
		int n, e;
		logic lv;
		for (int s = 0; s < 4; s++) begin
			timeout_select = 2'(s);
			kick_en = 1'b1;
			wait_rst(1'b0, HOLD + 20, n);
			quiet(400);
			`CHK("kicked", 1'b0, seen)
			// Stop on a fresh fall, or on a rise that must not count
			lv = s[0];
			repeat (32) if (watchdog_kick_n === lv) @(negedge clock);
			repeat (32) if (watchdog_kick_n !== lv) @(negedge clock);
			kick_en = 1'b0;
			e = per[s] - (s % 2) * 31;
			wait_rst(1'b1, 400, n);
			`CHK("period", 1'b1, n >= e - 6 && n <= e + 6)
			wait_rst(1'b0, HOLD + 20, n);
			`CHK("wd hold", 1'b1, n >= HOLD - 1)
		end
	endtask
	task automatic t_btn();
		int n;
		kick_en = 1'b1;
		manual_reset_n = 1'b0;
		repeat (5) @(negedge clock);
		manual_reset_n = 1'b1;
		quiet(30);
		`CHK("glitch", 1'b0, seen)
		manual_reset_n = 1'b0;
		wait_rst(1'b1, 20, n);
		`CHK("press", 1'b1, n >= 10)
		repeat (20) @(negedge clock);
		manual_reset_n = 1'b1;
		wait_rst(1'b0, HOLD + 20, n);
		`CHK("btn hold", 1'b1, n >= HOLD)
	endtask
	task automatic t_uv();
		int n;
		undervoltage = 1'b1;
		wait_rst(1'b1, 5, n);
		`CHK("oe active", 1'b0, rst_oe)
		`CHK("od data", 1'b0, rst_od)
		repeat (20) @(negedge clock);
		undervoltage = 1'b0;
		repeat (HOLD / 2) @(negedge clock);
		undervoltage = 1'b1;
		repeat (4) @(negedge clock);
		undervoltage = 1'b0;
		wait_rst(1'b0, HOLD + 20, n);
		`CHK("uv restart", 1'b1, n >= HOLD)
		`CHK("oe idle", 1'b1, rst_oe)
	endtask
	initial begin
		int n;
		repeat (5) @(negedge clock);
		rst_b = 1'b1;
		wait_rst(1'b0, HOLD + 20, n);
		`CHK("power hold", 1'b1, n >= HOLD - 1)
		t_wd();
		t_btn();
		t_uv();
		close_out();
	end
endmodule // psw_tb_top
